// [common/asm_pkg.sv]
package asm_pkg;

    // register offsets, byte addresses on the 8-bit register port
    localparam logic [7:0] OFS_MODE = 8'h00;
    localparam logic [7:0] OFS_ERR = 8'h04;
    localparam logic [7:0] OFS_RXBUF = 8'h08;
    localparam logic [7:0] OFS_TXBUF = 8'h0C;
    localparam logic [7:0] OFS_CKSEL = 8'h10;
    localparam logic [7:0] OFS_BAUD = 8'h14;

    // op_mode_reg fields
    localparam int MODE_PWR = 7;
    localparam int MODE_TXE = 6;
    localparam int MODE_RXE = 5;
    localparam int MODE_PSH = 4;
    localparam int MODE_PSL = 3;
    localparam int MODE_CL = 2;
    localparam int MODE_SL = 1;
    localparam int MODE_ISRM = 0;

    // rx_error_status_reg fields
    localparam int ERR_PE = 2;
    localparam int ERR_FE = 1;
    localparam int ERR_OVE = 0;

    // tx status fields, read at the tx buffer offset
    localparam int TXS_FULL = 1;
    localparam int TXS_BUSY = 0;

    // parity-select encodings
    localparam logic [1:0] PAR_NONE = 2'h0;
    localparam logic [1:0] PAR_ZERO = 2'h1;
    localparam logic [1:0] PAR_ODD = 2'h2;
    localparam logic [1:0] PAR_EVEN = 2'h3;

    // reset values
    localparam logic [7:0] MODE_RST = 8'h01;
    localparam logic [3:0] CKSEL_RST = 4'h0;
    localparam logic [7:0] BAUD_RST = 8'hFF;
    localparam logic [11:0] TX_IDLE_FRAME = 12'hFFF;

    // timing counts, in base clock ticks
    localparam logic [1:0] ENABLE_GUARD_TICKS = 2'h2;
    localparam logic [7:0] MIN_BIT_TICKS = 8'h02;

    localparam int TX_FIFO_DEPTH = 8;
    localparam int DATA_W = 8;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } asm_bus_req_t;

    typedef enum logic {
        TX_IDLE,
        TX_SHIFT
    } asm_tx_state_t;

    typedef enum logic {
        RX_IDLE,
        RX_BITS
    } asm_rx_state_t;

endpackage : asm_pkg

// [logic/asm_serial_port.sv]
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/1ps

module asm_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic flush,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int PW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [PW:0] cnt;
        logic [PW-1:0] rp;
        logic [PW-1:0] wp;
    } asm_fifo_st_t;

    asm_fifo_st_t q;
    asm_fifo_st_t n;
    logic push;
    logic pop;

    assign in_ready = (q.cnt != (PW+1)'(DEPTH));
    assign out_valid = (q.cnt != '0);
    assign out_data = q.mem[q.rp];

    always_comb
    begin
        n = q;
        push = in_valid && in_ready;
        pop = out_valid && out_ready;
        if (push)
        begin
            n.mem[q.wp] = in_data;
            n.wp = (q.wp == PW'(DEPTH - 1)) ? '0 : q.wp + 1'b1;
        end
        if (pop)
        begin
            n.rp = (q.rp == PW'(DEPTH - 1)) ? '0 : q.rp + 1'b1;
        end
        n.cnt = q.cnt + (PW+1)'(push) - (PW+1)'(pop);
        // flush drops queued bytes; the memory content is left as is
        if (flush)
        begin
            n.cnt = '0;
            n.rp = '0;
            n.wp = '0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            q <= '0;
        end
        else
        begin
            q <= n;
        end
    end

endmodule : asm_fifo

// Operation
// - low line at rx enable starts reception
// - enables base-clock synced; two-tick re-enable gap
// - stop length tx only; receiver uses one
// - parity error follows parity select mode
// - framing check looks at first stop only
// - pending overrun discards next character
// - error status read inserts a wait cycle
module asm_serial_port (
    input wire logic ref_clk,
    input wire logic reset,
    input asm_pkg::asm_bus_req_t bus_req,
    output logic [7:0] rd_data_q,
    output logic err_read_wait_q,
    input wire logic serial_rx_pin,
    output logic serial_tx_pin_q
);
    import asm_pkg::*;

    typedef struct packed {
        logic [7:0] mode;
        logic [3:0] cksel;
        logic [7:0] baud;
        logic [10:0] pre;
        logic tick;
        logic tx_en_s;
        logic rx_en_s;
        logic [1:0] tx_guard;
        logic [1:0] rx_guard;
        logic rx_meta;
        logic rx_sync;
        asm_tx_state_t tx_st;
        logic [7:0] tx_cnt;
        logic [3:0] tx_left;
        logic [11:0] tx_sh;
        asm_rx_state_t rx_st;
        logic [7:0] rx_cnt;
        logic [3:0] rx_idx;
        logic [7:0] rx_sh;
        logic rx_pbit;
        logic [7:0] rx_buf;
        logic rx_full;
        logic [2:0] err;
        logic [7:0] rd_data;
        logic rd_wait;
    } asm_port_st_t;

    localparam asm_port_st_t ST_RST = '{
        mode: MODE_RST,
        cksel: CKSEL_RST,
        baud: BAUD_RST,
        tx_st: TX_IDLE,
        tx_sh: TX_IDLE_FRAME,
        rx_st: RX_IDLE,
        rx_meta: 1'b1,
        rx_sync: 1'b1,
        default: '0
    };

    asm_port_st_t q;
    asm_port_st_t n;

    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [7:0] fifo_out_data;
    logic tx_pop;
    logic tx_push;

    // writes before the synced enable are dropped
    assign tx_push = bus_req.wr && (bus_req.addr == OFS_TXBUF) && q.tx_en_s;

    asm_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(TX_FIFO_DEPTH)
    ) u_tx_fifo (
        .ref_clk(ref_clk),
        .reset(reset),
        .flush(!q.tx_en_s),
        .in_valid(tx_push),
        .in_data(bus_req.wdata),
        .in_ready(fifo_in_ready),
        .out_valid(fifo_out_valid),
        .out_data(fifo_out_data),
        .out_ready(tx_pop)
    );

    assign rd_data_q = q.rd_data;
    assign err_read_wait_q = q.rd_wait;
    assign serial_tx_pin_q = q.tx_sh[0];

    always_comb
    begin
        logic [10:0] lim;
        logic [7:0] bper;
        logic [1:0] ps;
        logic [3:0] nd;
        logic [7:0] dm;
        logic pbit;
        logic smp;
        logic [11:0] frame;
        logic [7:0] rx_data;
        logic pe;
        logic rxbuf_read;
        lim = '0;
        bper = '0;
        ps = '0;
        nd = '0;
        dm = '0;
        pbit = 1'b0;
        smp = 1'b0;
        frame = '0;
        rx_data = '0;
        pe = 1'b0;
        rxbuf_read = 1'b0;
        n = q;
        tx_pop = 1'b0;

        // pin passes two flops before any use
        n.rx_meta = serial_rx_pin;
        n.rx_sync = q.rx_meta;
        n.rd_wait = 1'b0;
        n.rd_data = 8'h00;

        // base clock: one tick every 2**cksel reference clocks, held at 2048 for cksel 11 and above
        lim = (11'h001 << q.cksel) - 11'h001;
        n.tick = 1'b0;
        if (q.pre >= lim)
        begin
            n.pre = '0;
            n.tick = 1'b1;
        end
        else
        begin
            n.pre = q.pre + 11'h001;
        end

        bper = (q.baud < MIN_BIT_TICKS) ? MIN_BIT_TICKS : q.baud;
        ps = {q.mode[MODE_PSH], q.mode[MODE_PSL]};
        nd = q.mode[MODE_CL] ? 4'h8 : 4'h7;

        if (bus_req.wr)
        begin
            // format bits are taken as written; software keeps them stable while enabled
            unique case (bus_req.addr)
                OFS_MODE: n.mode = bus_req.wdata;
                OFS_CKSEL: n.cksel = bus_req.wdata[3:0];
                OFS_BAUD: n.baud = bus_req.wdata;
                default: ;
            endcase
        end

        if (bus_req.rd)
        begin
            unique case (bus_req.addr)
                OFS_MODE: n.rd_data = q.mode;
                OFS_ERR:
                begin
                    n.rd_data = {5'h00, q.err};
                    n.rd_wait = 1'b1;
                    n.err = 3'h0;
                end
                OFS_RXBUF:
                begin
                    n.rd_data = q.rx_buf;
                    n.rx_full = 1'b0;
                    rxbuf_read = 1'b1;
                end
                OFS_TXBUF:
                begin
                    n.rd_data[TXS_FULL] = !fifo_in_ready;
                    n.rd_data[TXS_BUSY] = (q.tx_st == TX_SHIFT);
                end
                OFS_CKSEL: n.rd_data = {4'h0, q.cksel};
                OFS_BAUD: n.rd_data = q.baud;
                default: n.rd_data = 8'h00;
            endcase
        end

        if (q.tick)
        begin
            if (!(q.mode[MODE_PWR] && q.mode[MODE_TXE]))
            begin
                n.tx_en_s = 1'b0;
                n.tx_guard = q.tx_en_s ? ENABLE_GUARD_TICKS
                    : ((q.tx_guard != 2'h0) ? q.tx_guard - 2'h1 : 2'h0);
            end
            else if (q.tx_guard != 2'h0)
            begin
                n.tx_guard = q.tx_guard - 2'h1;
            end
            else
            begin
                n.tx_en_s = 1'b1;
            end
            if (!(q.mode[MODE_PWR] && q.mode[MODE_RXE]))
            begin
                n.rx_en_s = 1'b0;
                n.rx_guard = q.rx_en_s ? ENABLE_GUARD_TICKS
                    : ((q.rx_guard != 2'h0) ? q.rx_guard - 2'h1 : 2'h0);
            end
            else if (q.rx_guard != 2'h0)
            begin
                n.rx_guard = q.rx_guard - 2'h1;
            end
            else
            begin
                n.rx_en_s = 1'b1;
            end
        end

        // parity bit of the outgoing byte
        dm = q.mode[MODE_CL] ? fifo_out_data : {1'b0, fifo_out_data[6:0]};
        unique case (ps)
            PAR_ODD: pbit = ~^dm;
            PAR_EVEN: pbit = ^dm;
            PAR_NONE, PAR_ZERO: pbit = 1'b0;
        endcase
        frame = TX_IDLE_FRAME;
        frame[0] = 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            if (i < int'(nd))
            begin
                frame[1 + i] = dm[i];
            end
        end
        if (ps != PAR_NONE)
        begin
            frame[1 + int'(nd)] = pbit;
        end

        unique case (q.tx_st)
            TX_IDLE:
            begin
                if (q.tx_en_s && fifo_out_valid && q.tick)
                begin
                    tx_pop = 1'b1;
                    n.tx_sh = frame;
                    n.tx_cnt = bper - 8'h01;
                    // stop length applies to tx only
                    n.tx_left = 4'h1 + nd + {3'h0, ps != PAR_NONE}
                        + (q.mode[MODE_SL] ? 4'h2 : 4'h1);
                    n.tx_st = TX_SHIFT;
                end
            end
            TX_SHIFT:
            begin
                if (q.tick)
                begin
                    if (q.tx_cnt != 8'h00)
                    begin
                        n.tx_cnt = q.tx_cnt - 8'h01;
                    end
                    else if (q.tx_left == 4'h1)
                    begin
                        n.tx_sh = TX_IDLE_FRAME;
                        n.tx_st = TX_IDLE;
                    end
                    else
                    begin
                        n.tx_sh = {1'b1, q.tx_sh[11:1]};
                        n.tx_left = q.tx_left - 4'h1;
                        n.tx_cnt = bper - 8'h01;
                    end
                end
            end
        endcase
        // a dropped enable aborts the frame at once
        if (!q.tx_en_s)
        begin
            n.tx_st = TX_IDLE;
            n.tx_sh = TX_IDLE_FRAME;
        end

        smp = q.rx_sync;
        unique case (q.rx_st)
            RX_IDLE:
            begin
                // level, not edge: a low line at enable is a start bit
                if (q.rx_en_s && !q.rx_sync)
                begin
                    n.rx_st = RX_BITS;
                    n.rx_cnt = bper >> 1;
                    n.rx_idx = 4'h0;
                end
            end
            RX_BITS:
            begin
                if (q.tick && (q.rx_cnt != 8'h00))
                begin
                    n.rx_cnt = q.rx_cnt - 8'h01;
                end
                else if (q.tick)
                begin
                    n.rx_cnt = bper - 8'h01;
                    n.rx_idx = q.rx_idx + 4'h1;
                    if (q.rx_idx == 4'h0)
                    begin
                        // start bit gone high at mid-bit: noise, back to idle
                        if (smp)
                        begin
                            n.rx_st = RX_IDLE;
                        end
                    end
                    else if (q.rx_idx <= nd)
                    begin
                        n.rx_sh = {smp, q.rx_sh[7:1]};
                    end
                    else if ((ps != PAR_NONE) && (q.rx_idx == nd + 4'h1))
                    begin
                        n.rx_pbit = smp;
                    end
                    else
                    begin
                        // first stop bit only; receiver fixed at one
                        n.rx_st = RX_IDLE;
                        rx_data = q.mode[MODE_CL] ? q.rx_sh : {1'b0, q.rx_sh[7:1]};
                        unique case (ps)
                            PAR_ODD: pe = !(^{rx_data, q.rx_pbit});
                            PAR_EVEN: pe = ^{rx_data, q.rx_pbit};
                            PAR_NONE, PAR_ZERO: pe = 1'b0;
                        endcase
                        // flags set after the read clear, so a set wins
                        n.err[ERR_PE] = n.err[ERR_PE] | pe;
                        n.err[ERR_FE] = n.err[ERR_FE] | !smp;
                        if (q.err[ERR_OVE])
                        begin
                            n.err[ERR_OVE] = n.err[ERR_OVE];
                        end
                        else if (q.rx_full && !rxbuf_read)
                        begin
                            n.err[ERR_OVE] = 1'b1;
                        end
                        else
                        begin
                            n.rx_buf = rx_data;
                            n.rx_full = 1'b1;
                        end
                    end
                end
            end
        endcase
        // a dropped enable abandons the frame in progress
        if (!q.rx_en_s)
        begin
            n.rx_st = RX_IDLE;
        end

        // power off clears rx_full, the error state and the prescaler
        if (!q.mode[MODE_PWR])
        begin
            n.rx_full = 1'b0;
            n.err = 3'h0;
            n.pre = '0;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            q <= ST_RST;
        end
        else
        begin
            q <= n;
        end
    end

endmodule : asm_serial_port

// [verification/asm_line_model.sv]
`timescale 1ns/1ps

module asm_line_model #(
    parameter int BIT_CLK = 4
) (
    input wire logic ref_clk,
    input wire logic tx_line,
    output logic rx_line
);
    logic [7:0] got_q[$];

    // line idles high, as a released line would
    initial rx_line = 1'b1;

    // frames are sent whole; a low stop bit and a wrong parity bit are the faults offered
    task automatic send(input logic [7:0] data, input logic par_en, input logic par_bit,
        input logic stop_val);
        logic [10:0] frame;
        int n;
        frame = par_en ? {stop_val, par_bit, data, 1'b0} : {1'b1, stop_val, data, 1'b0};
        n = par_en ? 11 : 10;
        for (int i = 0; i < n; i++)
        begin
            rx_line <= frame[i];
            repeat (BIT_CLK) @(posedge ref_clk);
        end
        if (!stop_val)
        begin
            rx_line <= 1'b1;
        end
    endtask : send

    // holds the line at one level for a number of clocks
    task automatic hold(input logic level, input int clks);
        rx_line <= level;
        repeat (clks) @(posedge ref_clk);
    endtask : hold

    // mid-bit sampling of the transmit line, LSB first
    initial
    begin : rx_side
        logic [7:0] v;
        forever
        begin
            @(negedge tx_line);
            repeat (BIT_CLK / 2) @(posedge ref_clk);
            for (int i = 0; i < 8; i++)
            begin
                repeat (BIT_CLK) @(posedge ref_clk);
                v[i] = tx_line;
            end
            repeat (BIT_CLK) @(posedge ref_clk);
            got_q.push_back(v);
        end
    end
endmodule : asm_line_model

// [verification/asm_port_props.sv]
`timescale 1ns/1ps

module asm_port_props (
    input wire logic ref_clk,
    input wire logic reset,
    input asm_pkg::asm_bus_req_t bus_req,
    input wire logic [7:0] rd_data_q,
    input wire logic err_read_wait_q,
    input wire logic serial_rx_pin,
    input wire logic serial_tx_pin_q
);
    import asm_pkg::*;

    wire rd_err = bus_req.rd && bus_req.addr == OFS_ERR;
    wire rd_txs = bus_req.rd && bus_req.addr == OFS_TXBUF;
    wire rd_gap = bus_req.rd && bus_req.addr == 8'h18;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    wait_after_err_a: assert property (rd_err |=> err_read_wait_q)
        else $error("no wait pulse after error status read");
    wait_only_err_a: assert property (err_read_wait_q |-> $past(rd_err))
        else $error("wait pulse without error status read");
    err_spare_bits_a: assert property (rd_err |=> rd_data_q[7:3] == 5'h00)
        else $error("error status spare bits not zero");
    read_idle_zero_a: assert property (!$past(bus_req.rd) |-> rd_data_q == 8'h00)
        else $error("read data outside the answer cycle");
    unmapped_zero_a: assert property (rd_gap |=> rd_data_q == 8'h00)
        else $error("unmapped read not zero");
    tx_status_bits_a: assert property (rd_txs |=> rd_data_q[7:2] == 6'h00)
        else $error("tx status spare bits not zero");
    // bit time never below two reference clocks
    tx_bit_min_a: assert property ($changed(serial_tx_pin_q) |=> $stable(serial_tx_pin_q))
        else $error("tx bit shorter than two cycles");
    tx_idle_reset_a: assert property ($fell(reset) |-> serial_tx_pin_q && !err_read_wait_q)
        else $error("outputs not idle after reset");
endmodule : asm_port_props

bind asm_serial_port asm_port_props asm_port_props_inst (
    .ref_clk(ref_clk),
    .reset(reset),
    .bus_req(bus_req),
    .rd_data_q(rd_data_q),
    .err_read_wait_q(err_read_wait_q),
    .serial_rx_pin(serial_rx_pin),
    .serial_tx_pin_q(serial_tx_pin_q)
);

// [verification/testbench.sv]
`timescale 1ns/1ps

`define CHK(act, exp) \
    begin \
        check_count++; \
        if ((act) !== (exp)) \
        begin \
            err_count++; \
            $display("mismatch at %0t: got %h, expected %h", $time, (act), (exp)); \
        end \
    end

module testbench;
    import asm_pkg::*;

    logic ref_clk;
    logic reset;
    asm_bus_req_t bus_req;
    logic [7:0] rd_data_q;
    logic err_read_wait_q;
    logic serial_rx_pin;
    logic serial_tx_pin_q;
    int err_count = 0;
    int check_count = 0;
    int cycles = 0;
    logic [7:0] rdv;
    logic waitv;

    asm_serial_port asm_serial_port_inst (
        .ref_clk(ref_clk),
        .reset(reset),
        .bus_req(bus_req),
        .rd_data_q(rd_data_q),
        .err_read_wait_q(err_read_wait_q),
        .serial_rx_pin(serial_rx_pin),
        .serial_tx_pin_q(serial_tx_pin_q)
    );

    // baud 4 at cksel 0: four ref clocks per bit
    asm_line_model #(.BIT_CLK(4)) asm_line_model_inst (
        .ref_clk(ref_clk),
        .tx_line(serial_tx_pin_q),
        .rx_line(serial_rx_pin)
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic report_and_stop();
        $display("checks %0d, errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
        begin
            $display("Run complete: PASS");
        end
        else
        begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        bus_req.wr <= 1'b0;
    endtask : wr

    // data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus_req.rd <= 1'b0;
        #1;
        rdv = rd_data_q;
        waitv = err_read_wait_q;
    endtask : rd

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        rd(a);
        `CHK(rdv, exp)
    endtask : rd_chk

    // settle time covers sync flops and the stop-bit store
    task automatic rx_frame(input logic [7:0] d, input logic pe, input logic pb, input logic st);
        asm_line_model_inst.send(d, pe, pb, st);
        repeat (4) @(posedge ref_clk);
    endtask : rx_frame

    task automatic check_reset_values();
        rd_chk(OFS_MODE, MODE_RST);
        rd_chk(OFS_CKSEL, 8'(CKSEL_RST));
        rd_chk(OFS_BAUD, BAUD_RST);
        rd_chk(OFS_ERR, 8'h00);
        `CHK(waitv, 1'b1)
        rd_chk(8'h18, 8'h00);
        rd_chk(OFS_TXBUF, 8'h00);
    endtask : check_reset_values

    task automatic check_tx_fifo();
        wr(OFS_CKSEL, 8'h00);
        wr(OFS_BAUD, 8'h04);
        // power first, then tx enable, two stops
        wr(OFS_MODE, 8'h80);
        wr(OFS_MODE, 8'hC6);
        // drop and re-enable at once; device keeps the guard
        wr(OFS_MODE, 8'h86);
        wr(OFS_MODE, 8'hC6);
        // wait out guard and sync before the first byte
        repeat (12) @(posedge ref_clk);
        for (int i = 0; i < 10; i++)
        begin
            wr(OFS_TXBUF, 8'h10 + 8'(i));
        end
        rd(OFS_TXBUF);
        `CHK(rdv[TXS_FULL], 1'b1)
        for (int i = 0; i < 800 && asm_line_model_inst.got_q.size() < 9; i++)
            @(posedge ref_clk);
        repeat (80) @(posedge ref_clk);
        `CHK(asm_line_model_inst.got_q.size(), 9)
        for (int i = 0; i < 9; i++)
            `CHK(asm_line_model_inst.got_q[i], 8'h10 + 8'(i))
        rd_chk(OFS_TXBUF, 8'h00);
        // tx enable off, then power off
        wr(OFS_MODE, 8'h86);
        wr(OFS_MODE, 8'h06);
    endtask : check_tx_fifo

    task automatic check_rx_basic();
        // irq mode rewritten only while rx is off
        wr(OFS_MODE, 8'h84);
        // rx enable after power, line high
        wr(OFS_MODE, 8'hA4);
        repeat (12) @(posedge ref_clk);
        rx_frame(8'h3C, 1'b0, 1'b0, 1'b1);
        rd_chk(OFS_RXBUF, 8'h3C);
        rd_chk(OFS_ERR, 8'h00);
    endtask : check_rx_basic

    task automatic check_overrun();
        // two stops set; next start sits in the second stop slot
        wr(OFS_MODE, 8'hA6);
        asm_line_model_inst.send(8'h5A, 1'b0, 1'b0, 1'b1);
        rx_frame(8'hC3, 1'b0, 1'b0, 1'b1);
        rd_chk(OFS_RXBUF, 8'h5A);
        rx_frame(8'h77, 1'b0, 1'b0, 1'b1);
        rd_chk(OFS_ERR, 8'h01 << ERR_OVE);
        rd_chk(OFS_RXBUF, 8'h5A);
        rx_frame(8'h69, 1'b0, 1'b0, 1'b1);
        rd_chk(OFS_RXBUF, 8'h69);
    endtask : check_overrun

    task automatic check_framing();
        rx_frame(8'hE1, 1'b0, 1'b0, 1'b0);
        rd_chk(OFS_ERR, 8'h01 << ERR_FE);
        rd_chk(OFS_RXBUF, 8'hE1);
    endtask : check_framing

    // line held low across the enable: a frame of zeros with a low stop
    task automatic check_low_enable();
        wr(OFS_MODE, 8'h86);
        fork
            asm_line_model_inst.hold(1'b0, 60);
            begin
                repeat (4) @(posedge ref_clk);
                wr(OFS_MODE, 8'hA6);
            end
        join
        // rx off before the line goes back high; second frame abandoned
        wr(OFS_MODE, 8'h86);
        asm_line_model_inst.hold(1'b1, 8);
        rd_chk(OFS_ERR, 8'h01 << ERR_FE);
        rd_chk(OFS_RXBUF, 8'h00);
    endtask : check_low_enable

    task automatic check_parity_modes();
        for (int p = 0; p < 4; p++)
        begin
            // parity changed with both enables off; p 0 is the LIN setting
            wr(OFS_MODE, 8'h84 | 8'(p << 3));
            wr(OFS_MODE, 8'hA4 | 8'(p << 3));
            repeat (12) @(posedge ref_clk);
            // 8'h33 has four ones: bit p[0] is wrong for both checked modes
            rx_frame(8'h33, p != 0, p[0], 1'b1);
            rd_chk(OFS_ERR, 8'(p[1]) << ERR_PE);
            rd_chk(OFS_RXBUF, 8'h33);
        end
    endtask : check_parity_modes

    task automatic check_short_char();
        // length rewritten with both enables off, even parity kept
        wr(OFS_MODE, 8'h9C);
        wr(OFS_MODE, 8'h98);
        wr(OFS_MODE, 8'hB8);
        repeat (12) @(posedge ref_clk);
        // seven bits 7'h31, even parity bit 1 in the eighth slot
        rx_frame(8'hB1, 1'b0, 1'b0, 1'b1);
        rd_chk(OFS_RXBUF, 8'h31);
        rd_chk(OFS_ERR, 8'h00);
        // tick every second clock, two ticks a bit: still four clocks per bit
        wr(OFS_MODE, 8'h98);
        wr(OFS_MODE, 8'h18);
        wr(OFS_CKSEL, 8'h01);
        wr(OFS_BAUD, 8'h02);
        wr(OFS_MODE, 8'h98);
        wr(OFS_MODE, 8'hD8);
        repeat (12) @(posedge ref_clk);
        wr(OFS_TXBUF, 8'h31);
        for (int i = 0; i < 200 && asm_line_model_inst.got_q.size() < 10; i++)
            @(posedge ref_clk);
        repeat (8) @(posedge ref_clk);
        `CHK(asm_line_model_inst.got_q.size(), 10)
        `CHK(asm_line_model_inst.got_q[9], 8'hB1)
        // tx enable off, then power off
        wr(OFS_MODE, 8'h98);
        wr(OFS_MODE, 8'h18);
    endtask : check_short_char

    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 6000)
        begin
            err_count++;
            report_and_stop();
        end
    end

    initial
    begin
        reset = 1'b1;
        bus_req = '0;
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        check_reset_values();
        check_tx_fifo();
        check_rx_basic();
        check_overrun();
        check_framing();
        check_low_enable();
        check_parity_modes();
        check_short_char();
        report_and_stop();
    end
endmodule : testbench
